//--- logic/hbc_pkg.sv
// Package for the dual H-bridge chopper control block.
// Assumes a 50 MHz system clock; all times are converted to cycle counts here.
package hbc_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_MHZ          = 50;
    localparam int OFF_US_0         = 7;
    localparam int OFF_US_1         = 16;
    localparam int OFF_US_HIZ       = 24;
    localparam int OFF_US_PD        = 32;
    localparam int DEGLITCH_US      = 10;
    localparam int BLANK_US         = 1;
    localparam int OFF_CYC_0        = OFF_US_0 * CLK_MHZ;
    localparam int OFF_CYC_1        = OFF_US_1 * CLK_MHZ;
    localparam int OFF_CYC_HIZ      = OFF_US_HIZ * CLK_MHZ;
    localparam int OFF_CYC_PD       = OFF_US_PD * CLK_MHZ;
    localparam int DEGLITCH_CYC     = DEGLITCH_US * CLK_MHZ;
    localparam int BLANK_CYC        = BLANK_US * CLK_MHZ;
    localparam int CNT_W            = 11;

    // Mixed decay fast fraction in percent
    localparam int MIX_PCT          = 30;
    localparam logic [6:0] FRAC_MAX = 7'h64;
    localparam logic [6:0] FRAC_RST = 7'h1e;

    // ==========================================================
    // Quad-level selector codes
    localparam logic [1:0] QL_LOW   = 2'h0;
    localparam logic [1:0] QL_HIGH  = 2'h1;
    localparam logic [1:0] QL_HIZ   = 2'h2;
    localparam logic [1:0] QL_PD    = 2'h3;

    // Terminal drive codes: {enable, level}
    typedef struct packed {
        logic oe;
        logic lvl;
    } hbc_term_t;

    typedef struct packed {
        hbc_term_t one;
        hbc_term_t two;
    } hbc_bridge_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_DRIVE = 4'b0010,
        ST_FAST  = 4'b0100,
        ST_SLOW  = 4'b1000
    } hbc_state_t;

endpackage

//--- logic/hbc_chopper.sv
// Dual H-bridge control: pin decode plus off-time current chopping.
// Assumes comparator results and quad-level codes are synchronous to clk_sys.
// How it works
// R1 - Direction/enable: enable low floats; dir 0 gives L/H, dir 1 gives H/L.
// R2 - Sleep request low floats every terminal of both bridges.
// R3 - PWM inputs 0,0 drive both terminals low (low-side brake).
// R4 - PWM inputs 1,1 drive both terminals high (high-side brake).
// R5 - PWM 1,0 drives forward H/L; 0,1 drives reverse L/H.
// R6 - Forward current flows terminal one to terminal two.
// R7 - Drive until trip, decay for the off period, then drive again.
// R8 - Off-time select maps to 7, 16, 24, 32 microseconds.
// R9 - Off-time ignored by ripple control; changes apply after 10 us deglitch.
// R10 - Fast decay reverses bridge polarity after trip.
// R11 - Slow decay turns on both low-side switches.
// R12 - Decay select: dynamic, ripple, mixed 30 percent, fast.
// R13 - Selector A steers bridge A, selector B steers bridge B.
// R14 - Mixed decay: fast for first 30 percent of off-time, then slow.
// R15 - Fast decay stops driving when current nears zero.
// R16 - Dynamic decay picks slow, mixed or fast and tunes fast fraction.
// R17 - Dynamic: overshoot adds fraction, long drive removes it, each cycle.
// R18 - Dynamic: a downward target step forces fast decay.
// R19 - Ripple control: slow decay until valley, off period varies.
// R20 - Valley sits 19 mA plus 1 percent of trip below trip.
// R21 - Trip comparator ignored for 1 us blanking after drive starts.
// R22 - Comparators and quad-level selectors arrive as synchronous coded inputs.
// R23 - Dynamic fraction step and long-drive limit are parameters.
module hbc_chopper
    import hbc_pkg::*;
#(
    parameter logic [6:0]  FRAC_STEP  = 7'h0a,
    parameter logic [10:0] LONG_DRIVE = 11'h3e8 // [R23]
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              clk_en,
    input  wire logic              low_power_request_n,
    input  wire logic              pwm_interface,
    input  wire logic [1:0]        bridge_drive_enable,
    input  wire logic [1:0]        bridge_direction,
    input  wire logic [1:0]        bridge_input_one,
    input  wire logic [1:0]        bridge_input_two,
    input  wire logic [1:0]        off_time_select,
    input  wire logic [1:0]        decay_select_a,
    input  wire logic [1:0]        decay_select_b,
    input  wire logic [1:0]        trip_level, // [R22]
    input  wire logic [1:0]        valley_level,
    input  wire logic [1:0]        zero_current,
    input  wire logic [1:0]        target_step_down,
    output hbc_bridge_t [1:0]      bridge_out,
    output logic [1:0]             chopping
);

    // ==========================================================
    // Functions
    function automatic logic [CNT_W-1:0] off_cycles(input logic [1:0] sel);
        logic [CNT_W-1:0] c;
        c = CNT_W'(OFF_CYC_0);
        if (sel == QL_HIGH) begin
            c = CNT_W'(OFF_CYC_1);
        end else if (sel == QL_HIZ) begin
            c = CNT_W'(OFF_CYC_HIZ);
        end else if (sel == QL_PD) begin
            c = CNT_W'(OFF_CYC_PD);
        end
        return c; // [R8]
    endfunction

    function automatic logic [CNT_W-1:0] frac_of(input logic [CNT_W-1:0] t,
                                                  input logic [6:0] pct);
        logic [17:0] p;
        p = 18'(t) * 18'(pct) / 18'd100;
        return p[CNT_W-1:0];
    endfunction

    // ==========================================================
    // Off-time select deglitch, shared by both bridges
    logic [1:0]        off_time_select_act_r;
    logic [1:0]        off_time_select_seen_r;
    logic [9:0]        dg_cnt_r;
    logic [CNT_W-1:0]  off_len;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            off_time_select_act_r  <= QL_LOW;
            off_time_select_seen_r <= QL_LOW;
            dg_cnt_r    <= 10'h0;
        end else if (clk_en) begin
            off_time_select_seen_r <= off_time_select;
            if (off_time_select != off_time_select_seen_r) begin
                dg_cnt_r <= 10'h0;
            end else if (off_time_select != off_time_select_act_r) begin
                if (dg_cnt_r == 10'(DEGLITCH_CYC - 1)) begin
                    off_time_select_act_r <= off_time_select; // [R9]
                    dg_cnt_r   <= 10'h0;
                end else begin
                    dg_cnt_r <= dg_cnt_r + 10'h1;
                end
            end else begin
                dg_cnt_r <= 10'h0;
            end
        end
    end

    assign off_len = off_cycles(off_time_select_act_r);

    // ==========================================================
    // Per-bridge chopper
    for (genvar b = 0; b < 2; b++) begin : g_br
        hbc_state_t        st_r;
        hbc_state_t        st_nxt;
        logic [CNT_W-1:0]  cnt_r;
        logic [6:0]        frac_r;
        logic [1:0]        dsel;
        logic              want_drive;
        logic              dir_fwd;
        logic              host_on;
        logic              blanked;
        logic              tripped;
        logic              off_done;
        logic              fast_done;
        logic [6:0]        pct;
        hbc_bridge_t       host_drv;
        hbc_bridge_t       drv;

        assign dsel = (b == 0) ? decay_select_a : decay_select_b; // [R13]

        // Host request decode; PWM brake patterns pass straight through
        assign host_on = pwm_interface
            ? (bridge_input_one[b] ^ bridge_input_two[b])
            : bridge_drive_enable[b];
        assign dir_fwd = pwm_interface ? bridge_input_one[b]
                                       : bridge_direction[b]; // [R6]
        assign want_drive = low_power_request_n && host_on;

        assign blanked  = cnt_r < CNT_W'(BLANK_CYC); // [R21]
        assign tripped  = trip_level[b] && !blanked;
        assign off_done = cnt_r >= off_len - CNT_W'(1);

        // Fast fraction for this cycle
        assign pct = (dsel == QL_PD)  ? FRAC_MAX // [R12]
                   : (dsel == QL_HIZ) ? 7'(MIX_PCT) // [R14]
                   : frac_r;                         // [R16]
        assign fast_done = cnt_r >= frac_of(off_len, pct);

        always_comb begin
            st_nxt = st_r;
            case (st_r)
                ST_IDLE: begin
                    if (want_drive) begin
                        st_nxt = ST_DRIVE;
                    end
                end
                ST_DRIVE: begin
                    if (!want_drive) begin
                        st_nxt = ST_IDLE;
                    end else if (tripped) begin // [R7]
                        if (dsel == QL_HIGH) begin
                            st_nxt = ST_SLOW; // [R19]
                        end else if (dsel == QL_LOW
                                     && target_step_down[b]) begin
                            st_nxt = ST_FAST; // [R18]
                        end else if (pct == 7'h0) begin
                            st_nxt = ST_SLOW;
                        end else begin
                            st_nxt = ST_FAST; // [R10]
                        end
                    end
                end
                ST_FAST: begin
                    if (!want_drive) begin
                        st_nxt = ST_IDLE;
                    end else if (off_done) begin
                        st_nxt = ST_DRIVE;
                    end else if (fast_done && !(dsel == QL_LOW
                                 && target_step_down[b])) begin
                        st_nxt = ST_SLOW; // [R14]
                    end
                end
                ST_SLOW: begin
                    if (!want_drive) begin
                        st_nxt = ST_IDLE;
                    end else if (dsel == QL_HIGH) begin
                        if (valley_level[b]) begin
                            st_nxt = ST_DRIVE; // [R19] [R20]
                        end
                    end else if (off_done) begin
                        st_nxt = ST_DRIVE; // [R7] [R9]
                    end
                end
                default: st_nxt = ST_IDLE;
            endcase
        end

        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                st_r   <= ST_IDLE;
                cnt_r  <= '0;
                frac_r <= FRAC_RST;
            end else if (clk_en) begin
                st_r <= st_nxt;
                if (st_nxt != st_r
                    && !(st_r == ST_FAST && st_nxt == ST_SLOW)) begin
                    cnt_r <= '0;
                end else if (cnt_r != {CNT_W{1'b1}}) begin
                    cnt_r <= cnt_r + CNT_W'(1);
                end
                // Tune fast fraction once per cycle at the trip point
                if (dsel == QL_LOW && st_r == ST_DRIVE && tripped) begin
                    if (cnt_r >= LONG_DRIVE) begin
                        frac_r <= (frac_r > FRAC_STEP)
                                ? frac_r - FRAC_STEP : 7'h0; // [R17]
                    end else if (cnt_r <= CNT_W'(BLANK_CYC)) begin
                        frac_r <= (frac_r < FRAC_MAX - FRAC_STEP)
                                ? frac_r + FRAC_STEP : FRAC_MAX; // [R17]
                    end
                end
            end
        end

        // Host table, with no chopping applied
        always_comb begin
            host_drv = '0;
            if (pwm_interface) begin
                host_drv.one = '{1'b1, bridge_input_one[b]}; // [R3] [R4] [R5]
                host_drv.two = '{1'b1, bridge_input_two[b]};
            end else if (bridge_drive_enable[b]) begin
                host_drv.one = '{1'b1, bridge_direction[b]}; // [R1]
                host_drv.two = '{1'b1, !bridge_direction[b]};
            end
        end

        // Decay drive follows the next state so it lines up with chopping
        always_comb begin
            drv = host_drv;
            case (st_nxt)
                ST_FAST: begin
                    drv.one = '{!zero_current[b], !dir_fwd}; // [R10] [R15]
                    drv.two = '{!zero_current[b], dir_fwd};
                end
                ST_SLOW: begin
                    drv.one = '{1'b1, 1'b0}; // [R11]
                    drv.two = '{1'b1, 1'b0};
                end
                default: drv = host_drv;
            endcase
            if (!low_power_request_n) begin
                drv = '0; // [R2]
            end
        end

        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                bridge_out[b] <= '0;
                chopping[b]   <= 1'b0;
            end else if (clk_en) begin
                bridge_out[b] <= drv;
                chopping[b]   <= (st_nxt == ST_FAST) || (st_nxt == ST_SLOW);
            end
        end
    end

endmodule

//--- tb/hbc_chk.sv
// Port-level assertions for the dual bridge chopper.
// Assumes one clock and the async active-low reset of the top module.
module hbc_chk
    import hbc_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rstn,
    input wire logic              clk_en,
    input wire logic              low_power_request_n,
    input wire logic              pwm_interface,
    input wire logic [1:0]        bridge_drive_enable,
    input wire logic [1:0]        bridge_direction,
    input wire logic [1:0]        bridge_input_one,
    input wire logic [1:0]        bridge_input_two,
    input wire logic [1:0]        decay_select_a,
    input wire logic [1:0]        decay_select_b,
    input wire logic [1:0]        trip_level,
    input wire hbc_bridge_t [1:0] bridge_out,
    input wire logic [1:0]        chopping
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Off-length and drive-length counters
    logic [10:0] hi_b_r;
    logic [10:0] lo_a_r;
    wire  logic  act = clk_en && low_power_request_n;
    wire  logic [3:0] oes = {bridge_out[0].one.oe, bridge_out[0].two.oe,
                             bridge_out[1].one.oe, bridge_out[1].two.oe};
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hi_b_r <= 11'h0;
            lo_a_r <= 11'h0;
        end else begin
            hi_b_r <= chopping[1] ? hi_b_r + 11'h1 : 11'h0;
            lo_a_r <= chopping[0] ? 11'h0 : lo_a_r + {10'h0, ~&lo_a_r};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_b_off_end;
        $fell(chopping[1]) && decay_select_b != QL_HIGH && !pwm_interface
        && $past(act && bridge_drive_enable[1]);
    endsequence
    a_sleep_float: assert property (
        clk_en && !low_power_request_n |=> oes == 4'h0)
        else $error("sleep left a terminal driven");
    a_enable_float: assert property (
        act && !pwm_interface && !bridge_drive_enable[0]
        |=> !bridge_out[0].one.oe && !bridge_out[0].two.oe)
        else $error("disabled bridge driven");
    a_dir_drive: assert property (
        act && !pwm_interface && bridge_drive_enable[0] && !chopping[0]
        && !trip_level[0] |=> bridge_out[0] == {1'b1,
        $past(bridge_direction[0]), 1'b1, !$past(bridge_direction[0])})
        else $error("direction drive wrong");
    a_pwm_brake: assert property (
        act && pwm_interface && !chopping[1]
        && bridge_input_one[1] == bridge_input_two[1]
        |=> bridge_out[1] == {2{1'b1, $past(bridge_input_one[1])}})
        else $error("brake pattern wrong");
    a_pwm_drive: assert property (
        act && pwm_interface && !chopping[0] && !trip_level[0]
        && bridge_input_one[0] != bridge_input_two[0]
        |=> bridge_out[0] == {1'b1, $past(bridge_input_one[0]), 1'b1,
        $past(bridge_input_two[0])})
        else $error("pwm drive wrong");
    a_ripple_slow: assert property (
        chopping[0] && decay_select_a == QL_HIGH && $stable(decay_select_a)
        && act && $past(act) |-> bridge_out[0] == 4'ha)
        else $error("ripple decay not low-side");
    a_fast_reverse: assert property (
        chopping[1] && decay_select_b == QL_PD && $stable(decay_select_b)
        && !pwm_interface && act && $past(act) |-> !bridge_out[1].one.oe
        || bridge_out[1].one.lvl != bridge_direction[1])
        else $error("fast decay not reversed");
    a_blank_hold: assert property (
        $rose(chopping[0]) |-> lo_a_r >= BLANK_CYC)
        else $error("trip taken inside blanking");
    a_off_length: assert property (
        s_b_off_end |-> hi_b_r inside {OFF_CYC_0, OFF_CYC_1, OFF_CYC_HIZ,
        OFF_CYC_PD})
        else $error("off period length wrong");
endmodule
bind hbc_chopper hbc_chk chk_u (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
    .low_power_request_n(low_power_request_n), .chopping(chopping),
    .pwm_interface(pwm_interface), .trip_level(trip_level),
    .bridge_drive_enable(bridge_drive_enable), .bridge_out(bridge_out),
    .bridge_direction(bridge_direction), .decay_select_a(decay_select_a),
    .bridge_input_one(bridge_input_one), .decay_select_b(decay_select_b),
    .bridge_input_two(bridge_input_two)
);

//--- tb/hbc_winding.sv
// Winding model: current rises on forward drive, falls in decay.
// Assumes the bench runs both bridges forward while chopping.
module hbc_winding
    import hbc_pkg::*;
#(
    parameter int TRIP = 100
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire hbc_bridge_t [1:0] bridge_out,
    output logic [1:0]             trip_level,
    output logic [1:0]             valley_level,
    output logic [1:0]             zero_current
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Current per bridge; slow decay is eight times gentler
    int cur [2];
    int tick;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cur = '{0, 0};
            tick = 0;
            trip_level <= 2'h0;
            valley_level <= 2'h0;
            zero_current <= 2'h0;
        end else begin
            tick = tick + 1;
            for (int i = 0; i < 2; i++) begin
                case (bridge_out[i])
                    4'he: cur[i] = cur[i] + 1;
                    4'ha, 4'hf: cur[i] = cur[i] - int'((tick % 8) == 0);
                    default: cur[i] = cur[i] - 1;
                endcase
                if (cur[i] < 0) cur[i] = 0;
                trip_level[i] <= cur[i] >= TRIP;
                valley_level[i] <= cur[i] < TRIP - 5;
                zero_current[i] <= cur[i] == 0;
            end
        end
    end
endmodule

//--- tb/tb_hbc_chopper.sv
// Self-checking bench for the dual bridge chopper.
// Assumes the winding model closes the current loop once enabled.
module tb_hbc_chopper
    import hbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_sys = 1'b0;
    logic              rstn = 1'b0;
    logic              clk_en = 1'b1;
    logic              low_power_request_n = 1'b1;
    logic              pwm_interface = 1'b0;
    logic              win_on = 1'b0;
    logic [1:0]        bridge_drive_enable = 2'h0;
    logic [1:0]        bridge_direction = 2'h0;
    logic [1:0]        bridge_input_one = 2'h0;
    logic [1:0]        bridge_input_two = 2'h0;
    logic [1:0]        off_time_select = QL_LOW;
    logic [1:0]        decay_select_a = QL_HIGH;
    logic [1:0]        decay_select_b = QL_PD;
    logic [1:0]        target_step_down = 2'h0;
    logic [1:0]        trip_level;
    logic [1:0]        w_trip;
    logic [1:0]        valley_level;
    logic [1:0]        zero_current;
    logic [1:0]        chopping;
    hbc_bridge_t [1:0] bridge_out;
    logic [31:0]       seed = 32'h8bf7a78c;
    logic [31:0]       r;
    logic [3:0]        ex [2];
    int                num_errors = 0;
    int                tests_run = 0;
    int                a_chops = 0;
    // ==========================================================
    // Design, winding and helpers
    assign trip_level = win_on ? w_trip : 2'h0;
    hbc_chopper dut_u (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
        .low_power_request_n(low_power_request_n), .chopping(chopping),
        .pwm_interface(pwm_interface), .bridge_out(bridge_out),
        .bridge_drive_enable(bridge_drive_enable), .trip_level(trip_level),
        .bridge_direction(bridge_direction), .valley_level(valley_level),
        .bridge_input_one(bridge_input_one), .zero_current(zero_current),
        .bridge_input_two(bridge_input_two), .off_time_select(off_time_select),
        .decay_select_a(decay_select_a), .decay_select_b(decay_select_b),
        .target_step_down(target_step_down));
    hbc_winding win_u (.clk_sys(clk_sys), .rstn(rstn), .bridge_out(bridge_out),
        .trip_level(w_trip), .valley_level(valley_level),
        .zero_current(zero_current));
    always #10 clk_sys = ~clk_sys;
    always @(posedge chopping[0]) a_chops++;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [3:0] msk(hbc_bridge_t t);
        return {t.one.oe, t.one.oe & t.one.lvl, t.two.oe, t.two.oe & t.two.lvl};
    endfunction
    function automatic logic [3:0] model(logic lp, logic pw, logic en,
                                         logic dir, logic i1, logic i2);
        if (!lp) return 4'h0;
        if (pw) return {1'b1, i1, 1'b1, i2};
        if (!en) return 4'h0;
        return {1'b1, dir, 1'b1, !dir};
    endfunction
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Times one off period of bridge B; mixed also checks fast then slow
    task automatic chop_b(int len, bit mixed);
        int n;
        n = 0;
        while (chopping[1] !== 1'b0 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        while (chopping[1] !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        n = 0;
        while (chopping[1] === 1'b1 && n < 3000) begin
            n++;
            if (mixed && n == 1)
                check("mix_fast", 4'hb, msk(bridge_out[1]));
            if (mixed && n == 300)
                check("mix_slow", 4'ha, msk(bridge_out[1]));
            @(negedge clk_sys);
        end
        check("off_len", len, n);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int k = 0; k < 400; k++) begin
            @(posedge clk_sys);
            for (int b = 0; b < 2; b++)
                ex[b] = model(low_power_request_n, pwm_interface,
                    bridge_drive_enable[b], bridge_direction[b],
                    bridge_input_one[b], bridge_input_two[b]);
            r = xs();
            low_power_request_n <= |r[2:0];
            pwm_interface <= r[3];
            bridge_drive_enable <= r[5:4];
            bridge_direction <= r[7:6];
            bridge_input_one <= r[9:8];
            bridge_input_two <= r[11:10];
            @(negedge clk_sys);
            for (int b = 0; b < 2; b++)
                check("bridge_out", ex[b],
                      msk(bridge_out[b]));
        end
        @(posedge clk_sys);
        low_power_request_n <= 1'b1;
        pwm_interface <= 1'b0;
        bridge_drive_enable <= 2'h3;
        bridge_direction <= 2'h3;
        win_on <= 1'b1;
        chop_b(OFF_CYC_0, 1'b0);
        @(posedge clk_sys);
        decay_select_b <= QL_HIZ;
        chop_b(OFF_CYC_0, 1'b1);
        @(posedge clk_sys);
        off_time_select <= QL_HIGH;
        chop_b(OFF_CYC_0, 1'b1);
        chop_b(OFF_CYC_1, 1'b1);
        @(posedge clk_sys);
        decay_select_b <= QL_LOW;
        target_step_down <= 2'h2;
        chop_b(OFF_CYC_1, 1'b0);
        check("ripple_chops", 1, a_chops > 0);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        final_report();
    end
endmodule
